// ### rtl/cpm_defines.svh
/*
 * named constants of the clock and power mode controller: register byte
 * addresses, key values, field positions and reset values.
 * assumes it is included by its bare name before any design code.
 */
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define CPM_ADDR_POWER_KEY_FIRST    32'hFFFF0404
`define CPM_ADDR_POWER_MODE_CONTROL 32'hFFFF0408
`define CPM_ADDR_POWER_KEY_SECOND   32'hFFFF040C
`define CPM_ADDR_CLOCK_KEY_FIRST    32'hFFFF0410
`define CPM_ADDR_CLOCK_SOURCE_CTRL  32'hFFFF0414
`define CPM_ADDR_CLOCK_KEY_SECOND   32'hFFFF0418
`define CPM_ADDR_CLOCK_STATUS       32'hFFFF041C

// ****************************************************************
// key values
// ****************************************************************
`define CPM_POWER_KEY_FIRST_VAL     16'h0001
`define CPM_POWER_KEY_SECOND_VAL    16'h00F4
`define CPM_CLOCK_KEY_FIRST_VAL     16'h00AA
`define CPM_CLOCK_KEY_SECOND_VAL    16'h0055

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CPM_DIV_LSB                 0
`define CPM_DIV_MSB                 2
`define CPM_MODE_LSB                4
`define CPM_MODE_MSB                6
`define CPM_SRC_LSB                 0
`define CPM_SRC_MSB                 1
`define CPM_OSC_SEL_BIT             5
`define CPM_POWER_RESET             8'h03
`define CPM_CLOCK_RESET             8'h21
`define CPM_SRC_PLL                 2'h1
`define CPM_SRC_EXT                 2'h3
`define CPM_STAT_LOCKED_BIT         0
`define CPM_STAT_RUN_BIT            1
`define CPM_STAT_ARMED_BIT          2

// ****************************************************************
// lock monitor figures
// ****************************************************************
`define CPM_PLL_MULT                1275
`define CPM_LOCK_TOL                8
`define CPM_LOCK_GOOD_N             2

`endif

// ### rtl/cpm_pkg.sv
/*
 * types shared by the clock and power mode controller files.
 * assumes nothing of its surroundings.
 */
`default_nettype none

package cpm_pkg;

  // operating mode codes
  typedef enum logic [2:0] {
    CPM_MODE_ACTIVE = 3'h0,
    CPM_MODE_PAUSE  = 3'h1,
    CPM_MODE_NAP    = 3'h2,
    CPM_MODE_SLEEP  = 3'h3,
    CPM_MODE_STOP   = 3'h4
  } cpm_mode_t;

  // key sequence states, gray along the path
  typedef enum logic [1:0] {
    CPM_KEY_IDLE  = 2'h0,
    CPM_KEY_ARMED = 2'h1,
    CPM_KEY_HELD  = 2'h3
  } cpm_key_state_t;

  // which protected register a sequence aims at
  typedef enum logic {
    CPM_TGT_POWER = 1'b0,
    CPM_TGT_CLOCK = 1'b1
  } cpm_target_t;

  // power domain enables
  typedef struct packed {
    logic core;
    logic periph;
    logic pll;
    logic xtal_timers;
    logic ext_irq;
  } cpm_domain_t;

  // wake sources
  typedef struct packed {
    logic ext_irq_zero;
    logic ext_irq_one;
    logic timer2;
    logic timer3;
    logic periph_irq;
  } cpm_wake_t;

endpackage : cpm_pkg

`default_nettype wire

// ### rtl/cpm_lock_monitor.sv
/*
 * pll lock monitor: counts system clock cycles between reference edges and
 * declares lock after a run of periods that match the multiplier.
 * assumes ref_edge is a one-cycle pulse already synchronised to core_clk.
 */
`default_nettype none
`include "cpm_defines.svh"

module cpm_lock_monitor #(
  parameter int unsigned MULT   = `CPM_PLL_MULT,
  parameter int unsigned TOL    = `CPM_LOCK_TOL,
  parameter int unsigned GOOD_N = `CPM_LOCK_GOOD_N
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic ref_edge,
  output logic      locked
);

  localparam logic [15:0] LO_LIM = 16'(MULT - TOL);
  localparam logic [15:0] HI_LIM = 16'(MULT + TOL);
  localparam logic [3:0]  GOOD   = 4'(GOOD_N);

  logic [15:0] period_cnt;  // cycles since last reference edge
  logic [3:0]  good_cnt;    // matching periods in a row

  // ****************************************************************
  // period counter and lock decision
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n || !run) begin
      period_cnt <= 16'h0000;
      good_cnt   <= 4'h0;
      locked     <= 1'b0;
    end else if (ref_edge) begin
      period_cnt <= 16'h0000;
      // one period of output cycles per reference edge
      if (period_cnt + 16'h0001 >= LO_LIM && period_cnt + 16'h0001 <= HI_LIM) begin
        if (good_cnt != GOOD) begin
          good_cnt <= good_cnt + 4'h1;
        end
        locked <= (good_cnt + 4'h1 >= GOOD);
      end else begin
        good_cnt <= 4'h0;
        locked   <= 1'b0;
      end
    end else if (period_cnt >= HI_LIM) begin
      // reference overdue: lock lost at once
      good_cnt <= 4'h0;
      locked   <= 1'b0;
    end else begin
      period_cnt <= period_cnt + 16'h0001;
    end
  end

endmodule : cpm_lock_monitor

`default_nettype wire

// ### rtl/cpm_clock_power_mode_control.sv
/*
 * clock source selection, core clock division and power mode control with
 * key-guarded control registers on an apb slave.
 * assumes core_clk stands for the pll output, pins arrive asynchronously and
 * timer and peripheral events come from logic on core_clk.
 */
// Local design decision: the APB interface to the registers.
// Overview of operation
// - pll multiplies 32.768 kHz reference by 1275
// - reset core clock is pll divided by 8
// - divider field divides by two to power
// - mode field selects active pause nap sleep stop
// - each mode powers down a larger domain set
// - sleep wakes on external irqs or timers
// - pause or nap resume restarts core promptly
// - oscillator select picks internal or crystal reference
// - source field picks pll or external pin
// - lock loss halts core when pll is the source, raises pll interrupt
// - clock control needs aa, value, 55 keys
// - power control needs 01, value, f4 keys
// - core clock may drive the output pin
`default_nettype none
`include "cpm_defines.svh"

module cpm_clock_power_mode_control #(
  parameter int unsigned PLL_MULT = `CPM_PLL_MULT,
  parameter int unsigned LOCK_TOL = `CPM_LOCK_TOL
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // asynchronous pins
  input  wire logic          int_osc_in,
  input  wire logic          xtal_in,
  input  wire logic          external_clock_pin,
  input  wire logic          ext_irq_zero,
  input  wire logic          ext_irq_one,
  // same-clock events and configuration
  input  wire logic          timer2_event,
  input  wire logic          timer3_event,
  input  wire logic          periph_irq,
  input  wire logic          clock_out_pin_cfg,
  // outputs
  output logic               core_clk_en,
  output cpm_pkg::cpm_domain_t domain_on,
  output logic               pll_irq,
  output logic               pll_locked,
  output logic               core_clock_out_pin,
  output logic               core_clock_out_oe
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [4:0] pin_raw;    // asynchronous pin levels
  logic [4:0] pin_meta;   // first stage, read only by second stage
  logic [4:0] pin_sync;   // second stage, safe to use
  logic       ref_hist;   // delayed copy for edge detect

  assign pin_raw = {ext_irq_one, ext_irq_zero, external_clock_pin, xtal_in, int_osc_in};

  // two flops per pin
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // control registers and key sequence state
  // ****************************************************************
  logic [7:0]                power_mode_control;    // mode and divider
  logic [7:0]                clock_source_control;  // osc select and source
  cpm_pkg::cpm_key_state_t   key_state;             // sequence progress
  cpm_pkg::cpm_target_t      key_target;            // register aimed at
  logic [7:0]                pend_val;              // value awaiting key two
  logic                      commit_power;          // one-cycle commit
  logic                      commit_clock;          // one-cycle commit
  logic                      clk_edge_prev;         // external clock history
  logic [6:0]                div_cnt;               // core divider count
  logic                      lock_raw;              // monitor output
  logic                      lock_prev;             // for loss detect
  logic                      wake;                  // wake condition

  // decoded fields
  logic [2:0]          div_sel;
  cpm_pkg::cpm_mode_t  mode;
  logic [1:0]          src_sel;
  logic                use_ext;
  logic                osc_int;
  cpm_pkg::cpm_wake_t  wake_src;

  assign div_sel = power_mode_control[`CPM_DIV_MSB:`CPM_DIV_LSB];
  assign src_sel = clock_source_control[`CPM_SRC_MSB:`CPM_SRC_LSB];
  assign osc_int = clock_source_control[`CPM_OSC_SEL_BIT];
  assign use_ext = (src_sel == `CPM_SRC_EXT);
  assign wake_src = '{ext_irq_zero: pin_sync[3], ext_irq_one: pin_sync[4],
                      timer2: timer2_event, timer3: timer3_event, periph_irq: periph_irq};

  // reserved mode codes behave as active
  always_comb begin
    case (power_mode_control[`CPM_MODE_MSB:`CPM_MODE_LSB])
      3'h1:    mode = cpm_pkg::CPM_MODE_PAUSE;
      3'h2:    mode = cpm_pkg::CPM_MODE_NAP;
      3'h3:    mode = cpm_pkg::CPM_MODE_SLEEP;
      3'h4:    mode = cpm_pkg::CPM_MODE_STOP;
      default: mode = cpm_pkg::CPM_MODE_ACTIVE;
    endcase
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic        wr_fire;     // write takes effect this edge
  logic        hit_pk1;
  logic        hit_pctl;
  logic        hit_pk2;
  logic        hit_ck1;
  logic        hit_cctl;
  logic        hit_ck2;
  logic        hit_stat;
  logic        hit_any;
  logic [31:0] rd_mux;      // read data for the addressed register

  assign wr_fire = psel && penable && pwrite && pready;

  // address compare, one register per word
  always_comb begin
    hit_pk1  = 1'b0;
    hit_pctl = 1'b0;
    hit_pk2  = 1'b0;
    hit_ck1  = 1'b0;
    hit_cctl = 1'b0;
    hit_ck2  = 1'b0;
    hit_stat = 1'b0;
    if (paddr == `CPM_ADDR_POWER_KEY_FIRST) begin
      hit_pk1 = 1'b1;
    end else if (paddr == `CPM_ADDR_POWER_MODE_CONTROL) begin
      hit_pctl = 1'b1;
    end else if (paddr == `CPM_ADDR_POWER_KEY_SECOND) begin
      hit_pk2 = 1'b1;
    end else if (paddr == `CPM_ADDR_CLOCK_KEY_FIRST) begin
      hit_ck1 = 1'b1;
    end else if (paddr == `CPM_ADDR_CLOCK_SOURCE_CTRL) begin
      hit_cctl = 1'b1;
    end else if (paddr == `CPM_ADDR_CLOCK_KEY_SECOND) begin
      hit_ck2 = 1'b1;
    end else if (paddr == `CPM_ADDR_CLOCK_STATUS) begin
      hit_stat = 1'b1;
    end
  end

  assign hit_any = hit_pk1 | hit_pctl | hit_pk2 | hit_ck1 | hit_cctl | hit_ck2 | hit_stat;

  // read mux: keys read zero, reserved bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_pctl) begin
      rd_mux[7:0] = power_mode_control;
    end else if (hit_cctl) begin
      rd_mux[7:0] = clock_source_control;
    end else if (hit_stat) begin
      rd_mux[`CPM_STAT_LOCKED_BIT] = lock_raw;
      rd_mux[`CPM_STAT_RUN_BIT]    = domain_on.core;
      rd_mux[`CPM_STAT_ARMED_BIT]  = (key_state != cpm_pkg::CPM_KEY_IDLE);
    end
  end

  // answer in the first access cycle; error on unmapped address
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !hit_any;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // key sequence
  // ****************************************************************
  logic key1_pwr;  // correct first power key written
  logic key1_clk;  // correct first clock key written

  assign key1_pwr = wr_fire && hit_pk1 && pwdata[15:0] == `CPM_POWER_KEY_FIRST_VAL;
  assign key1_clk = wr_fire && hit_ck1 && pwdata[15:0] == `CPM_CLOCK_KEY_FIRST_VAL;

  // any other write in between breaks the sequence
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      key_state    <= cpm_pkg::CPM_KEY_IDLE;
      key_target   <= cpm_pkg::CPM_TGT_POWER;
      pend_val     <= 8'h00;
      commit_power <= 1'b0;
      commit_clock <= 1'b0;
    end else begin
      commit_power <= 1'b0;
      commit_clock <= 1'b0;
      if (wr_fire) begin
        key_state <= cpm_pkg::CPM_KEY_IDLE;
        case (key_state)
          cpm_pkg::CPM_KEY_ARMED: begin
            // value write right after key one
            if ((key_target == cpm_pkg::CPM_TGT_POWER && hit_pctl) ||
                (key_target == cpm_pkg::CPM_TGT_CLOCK && hit_cctl)) begin
              key_state <= cpm_pkg::CPM_KEY_HELD;
              pend_val  <= pwdata[7:0];
            end
          end
          cpm_pkg::CPM_KEY_HELD: begin
            // key two commits the held value
            if (key_target == cpm_pkg::CPM_TGT_POWER && hit_pk2 &&
                pwdata[15:0] == `CPM_POWER_KEY_SECOND_VAL) begin
              commit_power <= 1'b1;
            end else if (key_target == cpm_pkg::CPM_TGT_CLOCK && hit_ck2 &&
                         pwdata[15:0] == `CPM_CLOCK_KEY_SECOND_VAL) begin
              commit_clock <= 1'b1;
            end
          end
          default: begin
          end
        endcase
        // a correct first key always starts a fresh sequence
        if (key1_pwr) begin
          key_state  <= cpm_pkg::CPM_KEY_ARMED;
          key_target <= cpm_pkg::CPM_TGT_POWER;
        end else if (key1_clk) begin
          key_state  <= cpm_pkg::CPM_KEY_ARMED;
          key_target <= cpm_pkg::CPM_TGT_CLOCK;
        end
      end
    end
  end

  // ****************************************************************
  // wake detection
  // ****************************************************************
  always_comb begin
    case (mode)
      cpm_pkg::CPM_MODE_PAUSE, cpm_pkg::CPM_MODE_NAP: begin
        wake = |wake_src;
      end
      cpm_pkg::CPM_MODE_SLEEP: begin
        // external irqs and timers 2 and 3 only
        wake = wake_src.ext_irq_zero | wake_src.ext_irq_one | wake_src.timer2 | wake_src.timer3;
      end
      cpm_pkg::CPM_MODE_STOP: begin
        wake = wake_src.ext_irq_zero | wake_src.ext_irq_one;
      end
      default: begin
        wake = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // protected registers
  // ****************************************************************
  // power control: commit wins over a wake in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      power_mode_control <= `CPM_POWER_RESET;
    end else if (commit_power) begin
      power_mode_control <= {1'b0, pend_val[6:4], 1'b0, pend_val[2:0]};
    end else if (wake) begin
      // back to active, divider kept
      power_mode_control[`CPM_MODE_MSB:`CPM_MODE_LSB] <= 3'h0;
    end
  end

  // clock control: only select and source bits are stored
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clock_source_control <= `CPM_CLOCK_RESET;
    end else if (commit_clock) begin
      clock_source_control <= {2'b00, pend_val[5], 3'b000, pend_val[1:0]};
    end
  end

  // ****************************************************************
  // power domains
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      domain_on <= '{core: 1'b1, periph: 1'b1, pll: 1'b1, xtal_timers: 1'b1, ext_irq: 1'b1};
    end else begin
      // each deeper mode drops one more domain
      domain_on.core        <= (mode == cpm_pkg::CPM_MODE_ACTIVE);
      domain_on.periph      <= (mode <= cpm_pkg::CPM_MODE_PAUSE);
      domain_on.pll         <= (mode <= cpm_pkg::CPM_MODE_NAP);
      domain_on.xtal_timers <= (mode <= cpm_pkg::CPM_MODE_SLEEP);
      domain_on.ext_irq     <= 1'b1;
    end
  end

  // ****************************************************************
  // pll lock monitor
  // ****************************************************************
  logic ref_edge;  // rising edge of selected reference

  // reference picked by the oscillator select bit
  assign ref_edge = (osc_int ? pin_sync[0] : pin_sync[1]) && !ref_hist;

  // reference history
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_hist <= 1'b0;
    end else begin
      ref_hist <= osc_int ? pin_sync[0] : pin_sync[1];
    end
  end

  cpm_lock_monitor #(
    .MULT   (PLL_MULT),
    .TOL    (LOCK_TOL),
    .GOOD_N (`CPM_LOCK_GOOD_N)
  ) u_lock (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (domain_on.pll),
    .ref_edge (ref_edge),
    .locked   (lock_raw)
  );

  // lock status and loss interrupt
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_prev  <= 1'b0;
      pll_locked <= 1'b0;
      pll_irq    <= 1'b0;
    end else begin
      lock_prev  <= lock_raw;
      pll_locked <= lock_raw;
      // one pulse on loss while the pll is powered
      pll_irq    <= lock_prev && !lock_raw && domain_on.pll;
    end
  end

  // ****************************************************************
  // core clock divider
  // ****************************************************************
  logic       base_tick;  // undivided core source tick
  logic [6:0] div_lim;    // 2^div - 1
  logic       div_term;   // divider at terminal count

  // external edge, or every cycle of a locked pll
  assign base_tick = use_ext ? (pin_sync[2] && !clk_edge_prev) : lock_raw;
  assign div_lim   = 7'((8'h01 << div_sel) - 8'h01);
  assign div_term  = (div_cnt == div_lim);

  // external clock edge history
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_edge_prev <= 1'b0;
    end else begin
      clk_edge_prev <= pin_sync[2];
    end
  end

  // divider count, cleared on wake so the core restarts after a whole divided period
  always_ff @(posedge core_clk) begin
    if (!rst_n || wake) begin
      div_cnt <= 7'h00;
    end else if (base_tick) begin
      div_cnt <= div_term ? 7'h00 : div_cnt + 7'h01;
    end
  end

  // core enable only while active
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      core_clk_en <= 1'b0;
    end else begin
      core_clk_en <= base_tick && div_term && (mode == cpm_pkg::CPM_MODE_ACTIVE);
    end
  end

  // ****************************************************************
  // core clock output pin
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      core_clock_out_pin <= 1'b0;
      core_clock_out_oe  <= 1'b0;
    end else begin
      core_clock_out_oe <= clock_out_pin_cfg;
      if (!clock_out_pin_cfg) begin
        core_clock_out_pin <= 1'b0;
      end else if (base_tick && div_term && mode == cpm_pkg::CPM_MODE_ACTIVE) begin
        core_clock_out_pin <= !core_clock_out_pin;
      end
    end
  end

endmodule : cpm_clock_power_mode_control

`default_nettype wire

// ### sim/cpm_asserts.sv
/* checker of bus timing, domain nesting and clock output pin of the controller.
   assumes it is bound to the controller top and sees its ports only. */
`default_nettype none
module cpm_asserts (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 pll_irq,
  input wire logic                 core_clk_en,
  input wire logic                 clock_out_pin_cfg,
  input wire logic                 core_clock_out_oe,
  input wire logic                 core_clock_out_pin,
  input wire cpm_pkg::cpm_domain_t domain_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // setup cycle of a transfer
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  a_ready_once: assert property (s_setup |=> s_answer) else $error("ready not one cycle");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_irq_pulse: assert property (pll_irq |=> !pll_irq) else $error("pll irq too long");
  a_core_gated: assert property (core_clk_en |-> domain_on.core) else $error("core tick while off");
  a_nest_pll: assert property (!domain_on.pll |-> !domain_on.core && !domain_on.periph) else $error("nest");
  a_nest_xtal: assert property (!domain_on.xtal_timers |-> !domain_on.pll) else $error("nest xtal");
  a_irq_kept: assert property (domain_on.ext_irq) else $error("irq domain off");
  a_oe_follows: assert property ($past(rst_n) |-> core_clock_out_oe == $past(clock_out_pin_cfg))
    else $error("oe mismatch");
  a_pin_quiet: assert property ($past(rst_n) && !$past(clock_out_pin_cfg) |-> !core_clock_out_pin)
    else $error("pin not quiet");
endmodule : cpm_asserts
bind cpm_clock_power_mode_control cpm_asserts u_cpm_asserts (.*);
`default_nettype wire

// ### sim/tb.sv
/* self-checking bench of the clock and power mode controller.
   assumes the design files and defines header are compiled first. */
`default_nettype none
`include "cpm_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, osc = 0, ref_run = 1, cfg = 0, ext = 0, err;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, core_clk_en, pll_irq, pll_locked;
  logic [4:0] wk = 0, ref_cnt = 0;
  cpm_pkg::cpm_domain_t domain_on;
  int bad_count = 0, tests_run = 0, n, p;
  always #5 core_clk = ~core_clk;
  // reference oscillator, period of 20 cycles
  always @(posedge core_clk) begin
    ref_cnt <= (ref_cnt == 5'h09) ? 5'h00 : ref_cnt + 5'h01;
    if (ref_run && ref_cnt == 5'h09) osc <= ~osc;
    // external clock pin, one rising edge every second cycle
    ext <= ~ext;
  end
  cpm_clock_power_mode_control #(.PLL_MULT(20), .LOCK_TOL(2)) u_cpm_clock_power_mode_control (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .int_osc_in(osc), .xtal_in(1'b0),
    .external_clock_pin(ext), .ext_irq_zero(wk[4]), .ext_irq_one(wk[3]), .timer2_event(wk[2]),
    .timer3_event(wk[1]), .periph_irq(wk[0]), .clock_out_pin_cfg(cfg), .core_clk_en(core_clk_en),
    .domain_on(domain_on), .pll_irq(pll_irq), .pll_locked(pll_locked), .core_clock_out_pin(),
    .core_clock_out_oe());
  task summarize;
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  // one apb transfer, held until ready is seen at a rising edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task key3(input logic [31:0] a1, k1, a2, v, a3, k3);
    apb(1'b1, a1, k1); apb(1'b1, a2, v); apb(1'b1, a3, k3);
    repeat (4) @(posedge core_clk);
  endtask : key3
  task setpow(input logic [31:0] v);
    key3(`CPM_ADDR_POWER_KEY_FIRST, 32'h1, `CPM_ADDR_POWER_MODE_CONTROL, v, `CPM_ADDR_POWER_KEY_SECOND, 32'hF4);
  endtask : setpow
  // cycles up to the next core tick, or to pll lock when want is low, bounded
  task wait_ev(input logic want, input int lim, output int c);
    c = 0;
    do begin @(posedge core_clk); c++; end while ((want ? core_clk_en : pll_locked) !== 1'b1 && c < lim);
  endtask : wait_ev
  task t_reset;
    apb(1'b0, `CPM_ADDR_POWER_MODE_CONTROL, 0); chk(rd, 32'h03);
    apb(1'b0, `CPM_ADDR_CLOCK_SOURCE_CTRL, 0); chk(rd, 32'h21);
    apb(1'b0, 32'hFFFF0420, 0); chk({31'h0, err}, 32'h1);
  endtask : t_reset
  task t_div;
    wait_ev(1'b0, 400, n); chk({31'h0, pll_locked}, 32'h1);
    for (int d = 3; d < 11; d++) begin
      if (d != 3) setpow(d % 8);
      wait_ev(1'b1, 300, n); wait_ev(1'b1, 300, n); wait_ev(1'b1, 300, p);
      chk(p, 1 << (d % 8));
    end
  endtask : t_div
  task t_keys;
    key3(`CPM_ADDR_POWER_KEY_FIRST, 32'h2, `CPM_ADDR_POWER_MODE_CONTROL, 7, `CPM_ADDR_POWER_KEY_SECOND, 32'hF4);
    apb(1'b1, `CPM_ADDR_POWER_MODE_CONTROL, 7); apb(1'b1, `CPM_ADDR_POWER_KEY_SECOND, 32'hF4);
    apb(1'b0, `CPM_ADDR_POWER_MODE_CONTROL, 0); chk(rd, 32'h02);
    key3(`CPM_ADDR_CLOCK_KEY_FIRST, 32'hAA, `CPM_ADDR_CLOCK_SOURCE_CTRL, 1, `CPM_ADDR_CLOCK_KEY_SECOND, 32'h55);
    apb(1'b0, `CPM_ADDR_CLOCK_SOURCE_CTRL, 0); chk(rd, 32'h01);
    repeat (60) @(posedge core_clk); chk({31'h0, pll_locked}, 32'h0);
    key3(`CPM_ADDR_CLOCK_KEY_FIRST, 32'hAA, `CPM_ADDR_CLOCK_SOURCE_CTRL, 32'h21, `CPM_ADDR_CLOCK_KEY_SECOND, 32'h56);
    apb(1'b0, `CPM_ADDR_CLOCK_SOURCE_CTRL, 0); chk(rd, 32'h01);
    // external pin as core source: 2 cycles a tick, divider 2 gives 8 cycles
    key3(`CPM_ADDR_CLOCK_KEY_FIRST, 32'hAA, `CPM_ADDR_CLOCK_SOURCE_CTRL, 32'h03,
         `CPM_ADDR_CLOCK_KEY_SECOND, 32'h55);
    wait_ev(1'b1, 300, n); wait_ev(1'b1, 300, p); chk(p, 8);
    key3(`CPM_ADDR_CLOCK_KEY_FIRST, 32'hAA, `CPM_ADDR_CLOCK_SOURCE_CTRL, 32'h21, `CPM_ADDR_CLOCK_KEY_SECOND, 32'h55);
    wait_ev(1'b0, 400, n); chk({31'h0, pll_locked}, 32'h1);
  endtask : t_keys
  // each low-power mode: domains, a refused waker in sleep and stop, then a real one
  task t_mode(input logic [2:0] m, input logic [4:0] dom, input logic [4:0] nope, input logic [4:0] yes);
    setpow({25'h0, m, 4'h2}); chk(domain_on, dom);
    wk <= nope; repeat (6) @(posedge core_clk); wk <= 5'h00;
    apb(1'b0, `CPM_ADDR_POWER_MODE_CONTROL, 0); chk(rd, {25'h0, m, 4'h2});
    wk <= yes; repeat (6) @(posedge core_clk); wk <= 5'h00;
    apb(1'b0, `CPM_ADDR_POWER_MODE_CONTROL, 0); chk(rd, 32'h02);
    wait_ev(1'b0, 400, n); wait_ev(1'b1, 10, n); chk(core_clk_en, 1'b1);
    chk(domain_on, 5'h1F);
  endtask : t_mode
  task t_loss;
    ref_run <= 1'b0; n = 0;
    do begin @(posedge core_clk); n++; end while (pll_irq !== 1'b1 && n < 100);
    chk(n < 100, 1'b1);
    n = 0;
    repeat (30) begin @(posedge core_clk); n += core_clk_en; end
    chk(n, 0);
    ref_run <= 1'b1; wait_ev(1'b0, 400, n);
  endtask : t_loss
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1; cfg <= 1'b1;
    t_reset; t_div; t_keys;
    t_mode(3'h1, 5'h0F, 5'h00, 5'h01); t_mode(3'h2, 5'h07, 5'h00, 5'h04);
    t_mode(3'h3, 5'h03, 5'h01, 5'h10); t_mode(3'h4, 5'h01, 5'h02, 5'h08);
    t_loss; summarize;
  end
  initial begin
    #400us; bad_count++; summarize;
  end
endmodule : tb
`default_nettype wire
